//--- logic/icd_pkg.sv
// Package for the instruction cache diagnostic access block.
// Assumes one core clock; every file refers to these names as icd_pkg::name.
package icd_pkg;

    // APB address width and data width.
    localparam int ADDR_W = 14;
    localparam int DATA_W = 32;

    // Register indices; the byte address is four times the index.
    localparam logic [11:0] IDX_SELECT = 12'h7C8;
    localparam logic [11:0] IDX_DATA0 = 12'h7C9;
    localparam logic [11:0] IDX_DATA1 = 12'h7CA;
    localparam logic [11:0] IDX_GO = 12'h7CB;
    localparam logic [11:0] IDX_FENCE = 12'h7CC;
    localparam logic [11:0] IDX_REGION = 12'h7CD;
    localparam logic [11:0] IDX_STATUS = 12'h7CE;

    // Selection register layout.
    localparam int SEL_ARRAY_BIT = 24;
    localparam int SEL_WAY_LSB = 20;
    localparam int SEL_IDX_LSB = 2;
    localparam int SEL_IDX_W = 14;
    localparam logic [31:0] SEL_WRITE_MASK = 32'h0130FFFC;
    localparam logic [31:0] SEL_RESET = 32'h00000000;

    // Array selector codes.
    localparam logic ARRAY_DATA = 1'b0;
    localparam logic ARRAY_TAG = 1'b1;

    // Cache geometry.
    localparam int NUM_WAYS = 4;
    localparam int WAY_W = 2;
    localparam int LINE_BYTES = 64;
    localparam int LINE_OFS_W = 6;
    localparam int CHUNK_LSB = 2;
    localparam int CHUNK_W = 4;
    localparam int CHUNKS_PER_LINE = 16;

    // Tag and status layout in data word zero.
    localparam int TAG_LSB = 12;
    localparam int TAG_W = 20;
    localparam int REC_LSB = 4;
    localparam int REC_W = 3;
    localparam int VALID_BIT = 0;

    // Check bit widths for the two protection schemes.
    localparam int DCHK_W = 10;
    localparam logic [9:0] DCHK_MASK_ECC = 10'h3FF;
    localparam logic [9:0] DCHK_MASK_PAR = 10'h003;
    localparam int TCHK_W = 5;
    localparam logic [4:0] TCHK_MASK_ECC = 5'h1F;
    localparam logic [4:0] TCHK_MASK_PAR = 5'h01;

    // Region control.
    localparam int NUM_REGIONS = 16;
    localparam int REGION_W = 4;
    localparam logic [15:0] REGION_RESET = 16'hFFFF;

    // Status register bits.
    localparam int STAT_ILLEGAL_BIT = 0;
    localparam int STAT_PRESENT_BIT = 1;
    localparam int STAT_ECC_BIT = 2;

    // Trigger bits in the go and fence registers.
    localparam int GO_BIT = 0;
    localparam int FENCE_BIT = 0;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_BUSY
    } icd_state_t;

    typedef struct packed {
        logic array_sel;
        logic [WAY_W-1:0] way;
        logic [15:0] index;
        logic [31:0] word0;
        logic [DCHK_W-1:0] word1;
    } icd_req_t;

    typedef struct packed {
        logic [31:0] word0;
        logic [DCHK_W-1:0] word1;
    } icd_rsp_t;

endpackage

//--- logic/icd_store.sv
// Flip-flop model of the cache arrays: data and tag storage plus status bits.
// Assumes single-cycle requests from the diagnostic controller on the same clock.
`timescale 1ns/1ps
module icd_store #(
    parameter int SETS = 8,
    parameter bit ECC_MODE = 1'b1
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Requests.
    input wire icd_pkg::icd_req_t req,
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic inval_all,
    // Answer.
    output icd_pkg::icd_rsp_t rsp
);
    localparam int SET_W = (SETS > 1) ? $clog2(SETS) : 1;
    localparam int LINES = icd_pkg::NUM_WAYS * SETS;

    // Data and tag words stand for SRAM and are not reset; status bits are flops.
    logic [icd_pkg::DATA_W+icd_pkg::DCHK_W-1:0] dmem [LINES*icd_pkg::CHUNKS_PER_LINE];
    logic [icd_pkg::TAG_W+icd_pkg::TCHK_W-1:0] tmem [LINES];
    logic [LINES-1:0] valid;
    logic [icd_pkg::REC_W-1:0] recency [SETS];

    wire [SET_W-1:0] set_sel = SET_W'(req.index >> icd_pkg::LINE_OFS_W);
    wire [icd_pkg::CHUNK_W-1:0] chunk = req.index[icd_pkg::CHUNK_LSB +: icd_pkg::CHUNK_W];
    wire [31:0] line = 32'(req.way) * 32'(SETS) + 32'(set_sel);
    wire [31:0] dword = line * 32'(icd_pkg::CHUNKS_PER_LINE) + 32'(chunk);
    wire [icd_pkg::DCHK_W-1:0] dmask = ECC_MODE ? icd_pkg::DCHK_MASK_ECC
                                                : icd_pkg::DCHK_MASK_PAR;
    wire [icd_pkg::TCHK_W-1:0] tmask = ECC_MODE ? icd_pkg::TCHK_MASK_ECC
                                                : icd_pkg::TCHK_MASK_PAR;
    wire is_tag = req.array_sel == icd_pkg::ARRAY_TAG;
    wire [icd_pkg::TAG_W+icd_pkg::TCHK_W-1:0] tword = tmem[line];
    wire [icd_pkg::DATA_W+icd_pkg::DCHK_W-1:0] dword_q = dmem[dword];

    // Check bits are stored as given, never regenerated here.
    always_ff @(posedge clk) begin
        if (wr_en && !is_tag) begin
            dmem[dword] <= {req.word0, req.word1 & dmask};
        end
        if (wr_en && is_tag) begin
            tmem[line] <= {req.word0[icd_pkg::TAG_LSB +: icd_pkg::TAG_W],
                           req.word1[icd_pkg::TCHK_W-1:0] & tmask};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valid <= '0;
            for (int s = 0; s < SETS; s++) begin
                recency[s] <= '0;
            end
        end else if (inval_all) begin
            valid <= '0;
        end else if (wr_en && is_tag) begin
            valid[line] <= req.word0[icd_pkg::VALID_BIT];
            recency[set_sel] <= req.word0[icd_pkg::REC_LSB +: icd_pkg::REC_W];
        end
    end

    // Read answer; sampled by the controller only when rd_en is high.
    always_comb begin
        rsp = '0;
        if (rd_en && !is_tag) begin
            rsp.word0 = dword_q[icd_pkg::DCHK_W +: icd_pkg::DATA_W];
            rsp.word1 = dword_q[icd_pkg::DCHK_W-1:0] & dmask;
        end else if (rd_en) begin
            rsp.word0[icd_pkg::TAG_LSB +: icd_pkg::TAG_W] = tword[icd_pkg::TCHK_W +: icd_pkg::TAG_W];
            rsp.word0[icd_pkg::REC_LSB +: icd_pkg::REC_W] = recency[set_sel];
            rsp.word0[icd_pkg::VALID_BIT] = valid[line];
            rsp.word1[icd_pkg::TCHK_W-1:0] = tword[icd_pkg::TCHK_W-1:0] & tmask;
        end
    end

endmodule

//--- logic/icd_diag.sv
// Diagnostic access and control for a four-way instruction cache, as an APB slave.
// Assumes the APB master and the core debug state run on CLK; DEBUG_MODE is same-clock.
//
// Notes on behaviour
// - Selection register holds array selector, way and line index of the target.
// - Array selector zero addresses the instruction data array with its check bits.
// - Array selector one addresses tag array, valid bit and set recency bits.
// - Way field takes values zero to three, one of four ways.
// - Reading the trigger with data array selected loads both data registers.
// - After data read, word zero is the instruction chunk, word one its checks.
// - Each chunk carries two parity or ten code bits, per protection build.
// - Writing one to trigger with data array selected stores both data registers.
// - Reading the trigger with tag array selected loads tag and status bits.
// - After tag read, word zero holds tag, valid, recency; word one tag checks.
// - Writing one to trigger with tag array selected stores tag, status, checks.
// - Diagnostic writes store check bits exactly as given, allowing error injection.
// - Lines are 64 bytes; line traversal starts at a 64-byte aligned index.
// - A debugger fence trigger write invalidates every cache entry.
// - Sixteen regions each have a cacheable bit; zero means not cached.
// - Instructions and tags sit in protected arrays; status bits in flops.
// - A build parameter decides whether the cache exists at all.
// - Diagnostic registers work only in debug mode; otherwise an illegal access.
// - Trigger bit reads zero and starts a write only when one is written.
// - Recency bits are shared by all ways of a set.
// - Index bits 5:2 pick one of the sixteen chunks within the line.
`timescale 1ns/1ps
module icd_diag #(
    parameter bit cache_present_param = 1'b1,
    parameter bit ECC_MODE = 1'b1,
    parameter int SETS = 8
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RESET_N,
    // APB slave.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [icd_pkg::ADDR_W-1:0] PADDR,
    input wire logic [icd_pkg::DATA_W-1:0] PWDATA,
    output logic [icd_pkg::DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Core debug state.
    input wire logic DEBUG_MODE,
    output logic ILLEGAL_ACCESS,
    // Fetch path cacheability.
    input wire logic [icd_pkg::REGION_W-1:0] FETCH_REGION,
    output logic FETCH_CACHEABLE,
    output logic [icd_pkg::NUM_REGIONS-1:0] REGION_CACHEABLE
);

    // Elaboration checks: sets must be a power of two and fit the index field.
    if (SETS < 1 || (SETS & (SETS - 1)) != 0) begin : g_bad_sets
        $error("SETS must be a power of two");
    end
    if ($clog2(SETS) + icd_pkg::LINE_OFS_W > 16) begin : g_bad_size
        $error("SETS too large for the index field");
    end

    // True for the registers that only debug mode may reach.
    function automatic logic is_diag_reg(input logic [11:0] idx);
        is_diag_reg = (idx == icd_pkg::IDX_SELECT) || (idx == icd_pkg::IDX_DATA0)
                   || (idx == icd_pkg::IDX_DATA1) || (idx == icd_pkg::IDX_GO);
    endfunction

    // True for every register this block answers for.
    function automatic logic is_mapped(input logic [11:0] idx);
        is_mapped = is_diag_reg(idx) || (idx == icd_pkg::IDX_FENCE)
                 || (idx == icd_pkg::IDX_REGION) || (idx == icd_pkg::IDX_STATUS);
    endfunction

    // Register state.
    logic [31:0] select_reg;
    logic [31:0] data0;
    logic [icd_pkg::DCHK_W-1:0] data1;
    logic [icd_pkg::NUM_REGIONS-1:0] region;
    logic illegal_seen;
    icd_pkg::icd_state_t state;
    icd_pkg::icd_state_t next_state;
    icd_pkg::icd_req_t req;
    icd_pkg::icd_rsp_t rsp;

    // Address decode.
    wire [11:0] reg_idx = PADDR[icd_pkg::ADDR_W-1:2];
    wire setup = PSEL && !PENABLE;
    wire access = PSEL && PENABLE;
    wire hit_select = reg_idx == icd_pkg::IDX_SELECT;
    wire hit_data0 = reg_idx == icd_pkg::IDX_DATA0;
    wire hit_data1 = reg_idx == icd_pkg::IDX_DATA1;
    wire hit_go = reg_idx == icd_pkg::IDX_GO;
    wire hit_fence = reg_idx == icd_pkg::IDX_FENCE;
    wire hit_region = reg_idx == icd_pkg::IDX_REGION;
    wire hit_status = reg_idx == icd_pkg::IDX_STATUS;
    wire mapped = is_mapped(reg_idx);
    wire blocked = is_diag_reg(reg_idx) && !DEBUG_MODE;

    // The trigger holds the bus one extra cycle so the array access finishes
    // before the transfer ends; any read that follows sees the result.
    wire go_access = access && hit_go && !blocked;
    wire go_start = go_access && (state == icd_pkg::ST_IDLE);
    wire done = access && PREADY;
    wire wr_ok = done && PWRITE && mapped && !blocked;
    wire cache_rd = go_start && !PWRITE;
    wire cache_wr = go_start && PWRITE && PWDATA[icd_pkg::GO_BIT];
    wire fence = wr_ok && hit_fence && PWDATA[icd_pkg::FENCE_BIT];

    wire [icd_pkg::DCHK_W-1:0] d1_mask = ECC_MODE ? icd_pkg::DCHK_MASK_ECC
                                                  : icd_pkg::DCHK_MASK_PAR;

    assign PREADY = !go_start;
    assign PSLVERR = done && (!mapped || blocked);

    always_comb begin
        next_state = state;
        case (state)
            icd_pkg::ST_IDLE: begin
                if (go_start) begin
                    next_state = icd_pkg::ST_BUSY;
                end
            end
            icd_pkg::ST_BUSY: begin
                next_state = icd_pkg::ST_IDLE;
            end
            default: begin
                next_state = icd_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state <= icd_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Request to the arrays, built from the selection and data registers.
    assign req.array_sel = select_reg[icd_pkg::SEL_ARRAY_BIT];
    assign req.way = select_reg[icd_pkg::SEL_WAY_LSB +: icd_pkg::WAY_W];
    assign req.index = {select_reg[icd_pkg::SEL_IDX_LSB +: icd_pkg::SEL_IDX_W], 2'b00};
    assign req.word0 = data0;
    assign req.word1 = data1;

    generate
        if (cache_present_param) begin : g_cache
            icd_store #(
                .SETS(SETS),
                .ECC_MODE(ECC_MODE)
            ) u_store (
                .clk(CLK),
                .rst_n(RESET_N),
                .req(req),
                .rd_en(cache_rd),
                .wr_en(cache_wr),
                .inval_all(fence),
                .rsp(rsp)
            );
        end else begin : g_no_cache
            assign rsp = '0;
        end
    endgenerate

    // Selection register; reserved bits stay zero.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            select_reg <= icd_pkg::SEL_RESET;
        end else if (wr_ok && hit_select) begin
            select_reg <= PWDATA & icd_pkg::SEL_WRITE_MASK;
        end
    end

    // Data registers: loaded by software writes or by a triggered read.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            data0 <= 32'h00000000;
            data1 <= '0;
        end else if (cache_rd) begin
            data0 <= rsp.word0;
            data1 <= rsp.word1;
        end else begin
            if (wr_ok && hit_data0) begin
                data0 <= PWDATA;
            end
            if (wr_ok && hit_data1) begin
                data1 <= PWDATA[icd_pkg::DCHK_W-1:0] & d1_mask;
            end
        end
    end

    // Region cacheable bits and the fetch-path lookup.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            region <= icd_pkg::REGION_RESET;
            FETCH_CACHEABLE <= 1'b0;
        end else begin
            if (wr_ok && hit_region) begin
                region <= PWDATA[icd_pkg::NUM_REGIONS-1:0];
            end
            FETCH_CACHEABLE <= region[FETCH_REGION] && cache_present_param;
        end
    end

    assign REGION_CACHEABLE = region;

    // Sticky record of a refused access; a new refusal beats a clear.
    wire clear_illegal = wr_ok && hit_status && PWDATA[icd_pkg::STAT_ILLEGAL_BIT];
    wire set_illegal = done && blocked;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            illegal_seen <= 1'b0;
            ILLEGAL_ACCESS <= 1'b0;
        end else begin
            ILLEGAL_ACCESS <= set_illegal;
            if (set_illegal) begin
                illegal_seen <= 1'b1;
            end else if (clear_illegal) begin
                illegal_seen <= 1'b0;
            end
        end
    end

    // Read data is captured in the setup cycle; nothing a read returns can
    // change before the access phase, so the value is safe to hold.
    logic [31:0] rd_mux;
    logic [31:0] status_word;

    always_comb begin
        status_word = 32'h00000000;
        status_word[icd_pkg::STAT_ILLEGAL_BIT] = illegal_seen;
        status_word[icd_pkg::STAT_PRESENT_BIT] = cache_present_param;
        status_word[icd_pkg::STAT_ECC_BIT] = ECC_MODE;
    end

    always_comb begin
        rd_mux = 32'h00000000;
        if (is_diag_reg(reg_idx) && !DEBUG_MODE) begin
            rd_mux = 32'h00000000;
        end else if (hit_select) begin
            rd_mux = select_reg;
        end else if (hit_data0) begin
            rd_mux = data0;
        end else if (hit_data1) begin
            rd_mux = 32'(data1);
        end else if (hit_region) begin
            rd_mux = 32'(region);
        end else if (hit_status) begin
            rd_mux = status_word;
        end
    end

    // The trigger and fence registers fall through to zero above.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PRDATA <= 32'h00000000;
        end else if (setup) begin
            PRDATA <= rd_mux;
        end
    end

endmodule

//--- testbench/icd_diag_sva.sv
// Checker for the cache diagnostic block, watching only its top-level ports.
// Assumes an APB master that holds each request steady until PREADY is high.
`timescale 1ns/1ps
module icd_diag_sva #(
    parameter bit cache_present_param = 1'b1,
    parameter bit ECC_MODE = 1'b1,
    parameter int SETS = 8
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RESET_N,
    // APB slave.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [icd_pkg::ADDR_W-1:0] PADDR,
    input wire logic [icd_pkg::DATA_W-1:0] PWDATA,
    input wire logic [icd_pkg::DATA_W-1:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Debug state and fetch path.
    input wire logic DEBUG_MODE,
    input wire logic ILLEGAL_ACCESS,
    input wire logic [icd_pkg::REGION_W-1:0] FETCH_REGION,
    input wire logic FETCH_CACHEABLE,
    input wire logic [icd_pkg::NUM_REGIONS-1:0] REGION_CACHEABLE
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    wire logic [11:0] idx = PADDR[13:2];
    wire logic setup = PSEL && !PENABLE;
    wire logic done = PSEL && PENABLE && PREADY;
    wire logic diag_reg = idx >= icd_pkg::IDX_SELECT && idx <= icd_pkg::IDX_GO;
    wire logic mapped = idx >= icd_pkg::IDX_SELECT && idx <= icd_pkg::IDX_STATUS;
    wire logic is_go = idx == icd_pkg::IDX_GO;
    wire logic fetch_bit = REGION_CACHEABLE[FETCH_REGION];

    go_wait_a: assert property (setup && is_go && DEBUG_MODE |=> !PREADY ##1 PREADY)
        else $error("diagnostic trigger access did not take exactly one wait state");
    no_wait_a: assert property (setup && (!is_go || !DEBUG_MODE) |=> PREADY)
        else $error("plain register access was stalled");
    refused_err_a: assert property (done && diag_reg && !DEBUG_MODE |-> PSLVERR && PRDATA == 0)
        else $error("diagnostic access outside debug mode was not refused");
    illegal_pulse_a: assert property (done && diag_reg && !DEBUG_MODE |=> ILLEGAL_ACCESS)
        else $error("refused access raised no illegal access pulse");
    illegal_cause_a: assert property (ILLEGAL_ACCESS |-> $past(done) && $past(PSLVERR))
        else $error("illegal access pulse without a refused transfer");
    mapped_ok_a: assert property (done && mapped && DEBUG_MODE |-> !PSLVERR)
        else $error("mapped access in debug mode reported an error");
    trig_zero_a: assert property (done && !PWRITE && (is_go || idx == icd_pkg::IDX_FENCE)
        |-> PRDATA == 0)
        else $error("trigger register did not read as zero");
    region_wr_a: assert property (done && PWRITE && idx == icd_pkg::IDX_REGION && DEBUG_MODE
        |=> REGION_CACHEABLE == $past(PWDATA[15:0]))
        else $error("region register did not take the written value");
    fetch_gate_a: assert property (1'b1 |=> FETCH_CACHEABLE == ($past(fetch_bit) && cache_present_param))
        else $error("fetch cacheability does not follow the region bit");
    status_a: assert property (done && !PWRITE && idx == icd_pkg::IDX_STATUS
        |-> PRDATA[2:1] == {ECC_MODE, cache_present_param})
        else $error("status does not report the build options");

    cover property (done && is_go && !PWRITE && DEBUG_MODE);
    cover property (done && is_go && PWRITE && DEBUG_MODE);
    cover property (done && diag_reg && !DEBUG_MODE);
    cover property (done && PWRITE && idx == icd_pkg::IDX_FENCE);
endmodule

bind icd_diag icd_diag_sva #(
    .cache_present_param(cache_present_param),
    .ECC_MODE(ECC_MODE),
    .SETS(SETS)
) icd_diag_sva_i (
    .CLK(CLK),
    .RESET_N(RESET_N),
    .PSEL(PSEL),
    .PENABLE(PENABLE),
    .PWRITE(PWRITE),
    .PADDR(PADDR),
    .PWDATA(PWDATA),
    .PRDATA(PRDATA),
    .PREADY(PREADY),
    .PSLVERR(PSLVERR),
    .DEBUG_MODE(DEBUG_MODE),
    .ILLEGAL_ACCESS(ILLEGAL_ACCESS),
    .FETCH_REGION(FETCH_REGION),
    .FETCH_CACHEABLE(FETCH_CACHEABLE),
    .REGION_CACHEABLE(REGION_CACHEABLE)
);

//--- testbench/testbench.sv
// Self-checking bench for the cache diagnostic block, driven over APB.
// Assumes the default build: cache present, ten code bits per data chunk.
`timescale 1ns/1ps
module testbench;
    localparam logic [13:0] A_SEL = {icd_pkg::IDX_SELECT, 2'b00};
    localparam logic [13:0] A_D0 = {icd_pkg::IDX_DATA0, 2'b00};
    localparam logic [13:0] A_D1 = {icd_pkg::IDX_DATA1, 2'b00};
    localparam logic [13:0] A_GO = {icd_pkg::IDX_GO, 2'b00};
    localparam logic [13:0] A_FEN = {icd_pkg::IDX_FENCE, 2'b00};
    localparam logic [13:0] A_REG = {icd_pkg::IDX_REGION, 2'b00};
    localparam logic [13:0] A_ST = {icd_pkg::IDX_STATUS, 2'b00};
    logic CLK, RESET_N, PSEL, PENABLE, PWRITE, DEBUG_MODE;
    logic PREADY, PSLVERR, ILLEGAL_ACCESS, FETCH_CACHEABLE;
    logic [13:0] PADDR;
    logic [31:0] PWDATA, PRDATA;
    logic [3:0] FETCH_REGION;
    logic [15:0] REGION_CACHEABLE;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;

    icd_diag icd_diag_i (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .DEBUG_MODE(DEBUG_MODE), .ILLEGAL_ACCESS(ILLEGAL_ACCESS),
        .FETCH_REGION(FETCH_REGION), .FETCH_CACHEABLE(FETCH_CACHEABLE),
        .REGION_CACHEABLE(REGION_CACHEABLE));

    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end

    task automatic final_report;
        $display("compares %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // The whole run needs about two thousand cycles.
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("ERROR %0t: run did not finish in time", $time);
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // PREADY and PRDATA are read at the edge, before that edge's register updates land.
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] wd,
        output logic [31:0] r, output logic er);
        int n;
        n = 0;
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 16);
        r = PRDATA;
        er = PSLVERR;
        chk({31'h0, PREADY}, 32'h1);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic e);
        logic [31:0] r;
        logic er;
        apb(1'b1, a, d, r, er);
        chk({31'h0, er}, {31'h0, e});
    endtask

    task automatic rd(input logic [13:0] a, input logic [31:0] x, input logic e);
        logic [31:0] r;
        logic er;
        apb(1'b0, a, 32'h0, r, er);
        chk({31'h0, er}, {31'h0, e});
        chk(r, x);
    endtask

    function automatic logic [31:0] pat(input int w, input int c);
        return 32'hA5000000 | 32'(w << 16) | 32'(c << 8) | 32'(w * 16 + c);
    endfunction

    function automatic logic [31:0] ck(input int w, input int c);
        return 32'((w * 16 + c) ^ 32'h2AA) & 32'h3FF;
    endfunction

    function automatic logic [31:0] tagw(input int w);
        return 32'hABC00000 + 32'(w << 12);
    endfunction

    // Chunk 15 is used on purpose: tag accesses must ignore the chunk bits.
    task automatic tagcheck(input logic v);
        for (int w = 0; w < 4; w++) begin
            wr(A_SEL, 32'h0100017C | 32'(w << 20), 1'b0);
            rd(A_GO, 32'h0, 1'b0);
            rd(A_D0, tagw(w) | 32'h30 | 32'(v), 1'b0);
            rd(A_D1, 32'h15 ^ 32'(w), 1'b0);
        end
    endtask

    initial begin
        RESET_N = 1'b0;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 14'h0;
        PWDATA = 32'h0;
        DEBUG_MODE = 1'b1;
        FETCH_REGION = 4'h0;
        repeat (20) @(posedge CLK);
        RESET_N <= 1'b1;
        rd(A_SEL, 32'h0, 1'b0);
        rd(A_REG, 32'hFFFF, 1'b0);
        rd(A_ST, 32'h6, 1'b0);
        wr(A_SEL, 32'hFFFFFFFF, 1'b0);
        rd(A_SEL, 32'h0130FFFC, 1'b0);
        rd(14'h1F3C, 32'h0, 1'b1);
        wr(14'h0000, 32'hFFFFFFFF, 1'b1);
        $display("test registers done");
        for (int w = 0; w < 4; w++) begin
            for (int c = 0; c < 16; c++) begin
                wr(A_SEL, 32'h140 + 32'(4 * c) + 32'(w << 20), 1'b0);
                wr(A_D0, pat(w, c), 1'b0);
                wr(A_D1, 32'hFFFFFC00 | ck(w, c), 1'b0);
                wr(A_GO, 32'h1, 1'b0);
            end
        end
        rd(A_D1, ck(3, 15), 1'b0);
        for (int w = 0; w < 4; w++) begin
            for (int c = 0; c < 16; c++) begin
                wr(A_SEL, 32'h140 + 32'(4 * c) + 32'(w << 20), 1'b0);
                rd(A_GO, 32'h0, 1'b0);
                rd(A_D0, pat(w, c), 1'b0);
                rd(A_D1, ck(w, c), 1'b0);
            end
        end
        wr(A_SEL, 32'h140, 1'b0);
        wr(A_D0, 32'hDEADBEEF, 1'b0);
        wr(A_GO, 32'h0, 1'b0);
        rd(A_GO, 32'h0, 1'b0);
        rd(A_D0, pat(0, 0), 1'b0);
        $display("test data array done");
        for (int w = 0; w < 4; w++) begin
            wr(A_SEL, 32'h01000140 | 32'(w << 20), 1'b0);
            wr(A_D0, tagw(w) | 32'hF8F | (w == 3 ? 32'h30 : 32'h50), 1'b0);
            wr(A_D1, 32'h15 ^ 32'(w), 1'b0);
            wr(A_GO, 32'h1, 1'b0);
        end
        tagcheck(1'b1);
        wr(A_FEN, 32'h1, 1'b0);
        rd(A_FEN, 32'h0, 1'b0);
        tagcheck(1'b0);
        $display("test tag array done");
        wr(A_REG, 32'h000000F0, 1'b0);
        @(posedge CLK);
        FETCH_REGION <= 4'h4;
        repeat (2) @(posedge CLK);
        #1 chk({31'h0, FETCH_CACHEABLE}, 32'h1);
        @(posedge CLK);
        FETCH_REGION <= 4'h3;
        repeat (2) @(posedge CLK);
        #1 chk({31'h0, FETCH_CACHEABLE}, 32'h0);
        wr(A_REG, 32'h0, 1'b0);
        rd(A_REG, 32'h0, 1'b0);
        $display("test regions done");
        @(posedge CLK);
        DEBUG_MODE <= 1'b0;
        wr(A_SEL, 32'h0, 1'b1);
        rd(A_D0, 32'h0, 1'b1);
        wr(A_GO, 32'h1, 1'b1);
        rd(A_ST, 32'h7, 1'b0);
        wr(A_ST, 32'h1, 1'b0);
        rd(A_ST, 32'h6, 1'b0);
        @(posedge CLK);
        DEBUG_MODE <= 1'b1;
        rd(A_SEL, 32'h0130017C, 1'b0);
        $display("test debug mode done");
        final_report();
    end
endmodule
